// file: fsr_drive_model.sv
// Floppy drive model on the drive interface pins
`timescale 1ns/1ps
module fsr_drive_model (
    input wire logic clk,
    input wire logic [3:0] motor_out,
    input wire logic wp,
    input wire logic trk,
    output wire fsr_pkg::fsr_pins_s pins
);
    logic [5:0] rot_q = 6'h00;
    logic spin;
    assign spin = motor_out != 4'h0;
    always @(posedge clk) begin
        rot_q <= spin ? rot_q + 6'h01 : 6'h00;
    end
    // Spindle turns only with a motor on; read data idles low
    assign pins.index_in = spin && rot_q[5:3] == 3'h7;
    assign pins.read_data_in = spin && rot_q[2];
    assign pins.track_zero_in = trk;
    assign pins.write_protect_in = wp;
    assign pins.second_drive_present_low = 1'b0;
    // Host side holds acknowledge and terminal count active
    assign pins.dma_ack_low = 1'b0;
    assign pins.term_count_in = 1'b1;
endmodule : fsr_drive_model

// file: fsr_pkg.sv
// Package with offsets, field positions, reset values and types of the status and output registers
package fsr_pkg;

    // Register offsets on the 3-bit host address
    localparam logic [2:0] OFS_STATUS_A = 3'h0;
    localparam logic [2:0] OFS_STATUS_B = 3'h1;
    localparam logic [2:0] OFS_OUTPUT_CONTROL = 3'h2;
    localparam logic [2:0] OFS_DIGITAL_INPUT = 3'h7;

    // Output control field positions
    localparam int OC_SEL_LO = 0;
    localparam int OC_SEL_HI = 1;
    localparam int OC_SOFT_RESET_N = 2;
    localparam int OC_DMA_GATE = 3;
    localparam int OC_MOTOR_LO = 4;
    localparam int OC_MOTOR_HI = 7;

    // Reset values
    localparam logic [7:0] OUTPUT_CONTROL_RST = 8'h00;
    localparam logic [7:0] STATUS_A_RST = 8'h09;
    localparam logic [7:0] STATUS_B_EXT_RST = 8'hc0;
    localparam logic [7:0] STATUS_B_CMP_RST = 8'h63;
    localparam logic [1:0] EXT_RESERVED = 2'h3;

    // Soft reset least duration
    localparam int SOFT_RESET_MIN_NS = 100;
    localparam int CLK_PERIOD_PS = 4000;

    // Pin input synchroniser depth
    localparam int SYNC_STAGES = 3;

    // Interface modes, coded as {mfm, ident}
    typedef enum logic [1:0] {
        FSR_MODE_COMPACT = 2'b00,
        FSR_MODE_EXTENDED = 2'b10,
        FSR_MODE_BASIC = 2'b11
    } fsr_mode_e;

    // Asynchronous drive and DMA pins sampled by the block
    typedef struct packed {
        logic index_in;
        logic track_zero_in;
        logic write_protect_in;
        logic second_drive_present_low;
        logic read_data_in;
        logic dma_ack_low;
        logic term_count_in;
    } fsr_pins_s;

    localparam int PIN_COUNT = $bits(fsr_pins_s);

    // Drive-side signals from the command engine on the same clock
    typedef struct packed {
        logic step_out;
        logic step_inward;
        logic head_side_select;
        logic write_gate;
        logic write_data;
        logic dma_req;
        logic fdc_irq;
    } fsr_engine_s;

    // Configuration bits
    typedef struct packed {
        logic [1:0] iface_mode;
        logic external_decode_sel;
        logic swap_drives;
        logic force_write_protect;
    } fsr_cfg_s;

endpackage : fsr_pkg

// file: fsr_regs.sv
// Floppy status registers, output control register and drive select decode
//
// Behaviour
// - Compact status A bit 0: 0 inward, 1 outward step, resets to 1.
// - Compact status A bit 1 is write protect, or forced protect setting.
// - Compact status A: bit 3 inverted head side, bit 2 index, bit 4 track zero.
// - Compact status A bit 5 latches step; cleared by input register read or reset.
// - Compact status A bit 6 shows DMA request, bit 7 interrupt; reset 0.
// - Basic mode leaves data bus undriven on status A or B reads.
// - Extended status B bits 0,1 mirror motors 0,1; hardware reset only.
// - Extended status B: bit 2 write gate, bits 3,4 toggle on data edges.
// - Extended status B bit 5 mirrors output control bit 0.
// - Extended status B bits 6 and 7 always read one.
// - Compact status B shows drive selects active low and second drive present.
// - Compact status B bit 2 latches write gate rise, cleared by input read.
// - Compact status B bits 3,4 latch read and write data falling edges.
// - Output control bits 0,1 encode the one selected drive of four.
// - Output control bit 2 low holds soft reset; only the status A step latch clears.
// - Soft reset lasts at least 100 ns even for back-to-back writes.
// - Basic and compact: bit 3 gates DMA and interrupt pins; reset 0.
// - Extended mode keeps DMA and interrupt pins enabled, even in reset.
// - Output control bits 4 to 7 drive motor outputs 0 to 3.
// - Output control is read/write, hardware reset clears, soft reset keeps.
// - Configuration picks internal or external select decode, and drive swap.
// - Internal decode drives select 0 or 1 low with its motor bit.
`timescale 1ns/1ps

module fsr_regs #(
    parameter int CLK_PERIOD_PS = fsr_pkg::CLK_PERIOD_PS,
    parameter int SOFT_RESET_MIN_NS = fsr_pkg::SOFT_RESET_MIN_NS
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [2:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rdata_oe,
    input wire fsr_pkg::fsr_cfg_s cfg,
    input wire fsr_pkg::fsr_pins_s pins,
    input wire fsr_pkg::fsr_engine_s engine,
    output logic soft_reset_n,
    output logic [3:0] drive_sel_out,
    output logic [3:0] motor_out,
    output logic drive_sel_pin0_low,
    output logic drive_sel_pin1_low,
    output logic motor_pin0_low,
    output logic motor_pin1_low,
    output logic dma_req_pin,
    output logic dma_req_oe,
    output logic fdc_irq_out,
    output logic fdc_irq_oe,
    output logic dma_ack_gated_low,
    output logic term_count_gated,
    output logic dma_gate_enable
);

    localparam int SRST_CYC_RAW = (SOFT_RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SRST_CYC = (SRST_CYC_RAW < 1) ? 1 : SRST_CYC_RAW;
    localparam logic [7:0] SRST_CNT_LOAD = 8'(SRST_CYC);

    if (SRST_CYC > 255 || CLK_PERIOD_PS < 1) begin : g_bad_timing
        $error("fsr_regs: soft reset count does not fit its counter");
    end

    // Pin synchronisers: three stages, value taken once stages two and three agree
    logic [fsr_pkg::PIN_COUNT-1:0] pin_raw;
    logic [fsr_pkg::PIN_COUNT-1:0] pin_filt_q;
    fsr_pkg::fsr_pins_s pin_f;

    assign pin_raw = pins;

    for (genvar i = 0; i < fsr_pkg::PIN_COUNT; i++) begin : g_sync
        logic [fsr_pkg::SYNC_STAGES-1:0] stg_q;
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                stg_q <= '0;
            end else begin
                stg_q <= {stg_q[fsr_pkg::SYNC_STAGES-2:0], pin_raw[i]};
            end
        end
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                pin_filt_q[i] <= 1'b0;
            end else if (stg_q[1] == stg_q[2]) begin
                pin_filt_q[i] <= stg_q[2];
            end
        end
    end

    assign pin_f = pin_filt_q;

    // Mode and host strobes
    fsr_pkg::fsr_mode_e mode;
    logic mode_basic;
    logic mode_ext;
    logic mode_cmp;
    logic wr_oc;
    logic rd_dir;

    always_comb begin
        unique case (cfg.iface_mode)
            2'b00: mode = fsr_pkg::FSR_MODE_COMPACT;
            2'b10: mode = fsr_pkg::FSR_MODE_EXTENDED;
            2'b11: mode = fsr_pkg::FSR_MODE_BASIC;
            default: mode = fsr_pkg::FSR_MODE_BASIC;
        endcase
    end

    assign mode_basic = (mode == fsr_pkg::FSR_MODE_BASIC);
    assign mode_ext = (mode == fsr_pkg::FSR_MODE_EXTENDED);
    assign mode_cmp = (mode == fsr_pkg::FSR_MODE_COMPACT);
    assign wr_oc = io_wr && (io_addr == fsr_pkg::OFS_OUTPUT_CONTROL);
    assign rd_dir = io_rd && (io_addr == fsr_pkg::OFS_DIGITAL_INPUT);

    // Output control register, hardware reset only
    logic [7:0] oc_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            oc_q <= fsr_pkg::OUTPUT_CONTROL_RST;
        end else if (wr_oc) begin
            oc_q <= io_wdata;
        end
    end

    // Soft reset stretch so that a clear then set pair still lasts long enough
    logic [7:0] srst_cnt_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            srst_cnt_q <= SRST_CNT_LOAD;
        end else if (wr_oc && !io_wdata[fsr_pkg::OC_SOFT_RESET_N]) begin
            srst_cnt_q <= SRST_CNT_LOAD;
        end else if (srst_cnt_q != 8'h00) begin
            srst_cnt_q <= srst_cnt_q - 8'h01;
        end
    end

    logic soft_rst;
    assign soft_rst = !oc_q[fsr_pkg::OC_SOFT_RESET_N] || (srst_cnt_q != 8'h00);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            soft_reset_n <= 1'b0;
        end else begin
            soft_reset_n <= !soft_rst;
        end
    end

    // Logical drive select and motor outputs
    logic [1:0] sel;
    logic [3:0] mot;
    assign sel = oc_q[fsr_pkg::OC_SEL_HI:fsr_pkg::OC_SEL_LO];
    assign mot = oc_q[fsr_pkg::OC_MOTOR_HI:fsr_pkg::OC_MOTOR_LO];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drive_sel_out <= 4'h0;
            motor_out <= 4'h0;
        end else begin
            drive_sel_out <= 4'h1 << sel;
            motor_out <= mot;
        end
    end

    // Pin decode with optional swap of drives 0 and 1
    logic [1:0] eff_sel;
    logic [3:0] eff_mot;
    assign eff_sel = sel ^ {1'b0, cfg.swap_drives & ~sel[1]};
    assign eff_mot = cfg.swap_drives ? {mot[3], mot[2], mot[0], mot[1]} : mot;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drive_sel_pin0_low <= 1'b1;
            drive_sel_pin1_low <= 1'b1;
            motor_pin0_low <= 1'b1;
            motor_pin1_low <= 1'b1;
        end else if (cfg.external_decode_sel) begin
            drive_sel_pin0_low <= eff_sel[0];
            drive_sel_pin1_low <= eff_sel[1];
            motor_pin0_low <= !eff_mot[eff_sel];
            motor_pin1_low <= 1'b1;
        end else begin
            drive_sel_pin0_low <= !((eff_sel == 2'h0) && eff_mot[0]);
            drive_sel_pin1_low <= !((eff_sel == 2'h1) && eff_mot[1]);
            motor_pin0_low <= !eff_mot[0];
            motor_pin1_low <= !eff_mot[1];
        end
    end

    // DMA and interrupt gating
    logic gate_en;
    assign gate_en = mode_ext || oc_q[fsr_pkg::OC_DMA_GATE];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dma_req_pin <= 1'b0;
            fdc_irq_out <= 1'b0;
            dma_ack_gated_low <= 1'b1;
            term_count_gated <= 1'b0;
        end else begin
            dma_req_pin <= engine.dma_req;
            fdc_irq_out <= engine.fdc_irq;
            dma_ack_gated_low <= pin_f.dma_ack_low || !gate_en;
            term_count_gated <= pin_f.term_count_in && gate_en;
        end
    end

    assign dma_req_oe = gate_en;
    assign fdc_irq_oe = gate_en;
    assign dma_gate_enable = oc_q[fsr_pkg::OC_DMA_GATE];

    // Edge detection on engine strobes and synchronised read data
    logic step_d1_q;
    logic write_gate_d1_q;
    logic wdata_d1_q;
    logic rdata_d1_q;
    logic step_rise;
    logic write_gate_rise;
    logic wdata_fall;
    logic rdata_fall;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            step_d1_q <= 1'b0;
            write_gate_d1_q <= 1'b0;
            wdata_d1_q <= 1'b0;
            rdata_d1_q <= 1'b0;
        end else begin
            step_d1_q <= engine.step_out;
            write_gate_d1_q <= engine.write_gate;
            wdata_d1_q <= engine.write_data;
            rdata_d1_q <= pin_f.read_data_in;
        end
    end

    assign step_rise = engine.step_out && !step_d1_q;
    assign write_gate_rise = engine.write_gate && !write_gate_d1_q;
    assign wdata_fall = !engine.write_data && wdata_d1_q;
    assign rdata_fall = !pin_f.read_data_in && rdata_d1_q;

    // Compact latches: set wins over the clearing read
    logic step_ff_q;
    logic write_gate_ff_q;
    logic rdata_ff_q;
    logic wdata_ff_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            step_ff_q <= 1'b0;
        end else if (step_rise) begin
            step_ff_q <= 1'b1;
        end else if (rd_dir || soft_rst) begin
            step_ff_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            write_gate_ff_q <= 1'b0;
            rdata_ff_q <= 1'b0;
            wdata_ff_q <= 1'b0;
        end else begin
            write_gate_ff_q <= write_gate_rise || (write_gate_ff_q && !rd_dir);
            rdata_ff_q <= rdata_fall || (rdata_ff_q && !rd_dir);
            wdata_ff_q <= wdata_fall || (wdata_ff_q && !rd_dir);
        end
    end

    // Extended toggles
    logic rdata_tog_q;
    logic wdata_tog_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_tog_q <= 1'b0;
            wdata_tog_q <= 1'b0;
        end else begin
            rdata_tog_q <= rdata_tog_q ^ rdata_fall;
            wdata_tog_q <= wdata_tog_q ^ wdata_fall;
        end
    end

    // Status views
    logic [7:0] sta_cmp;
    logic [7:0] sta_ext;
    logic [7:0] stb_ext;
    logic [7:0] stb_cmp;
    logic wp_eff;

    assign wp_eff = pin_f.write_protect_in || cfg.force_write_protect;

    always_comb begin
        sta_cmp = {engine.fdc_irq, engine.dma_req, step_ff_q, pin_f.track_zero_in,
                   !engine.head_side_select, pin_f.index_in, wp_eff,
                   !engine.step_inward};
        sta_ext = {engine.fdc_irq, pin_f.second_drive_present_low, engine.step_out,
                   !pin_f.track_zero_in, engine.head_side_select, !pin_f.index_in,
                   !wp_eff, engine.step_inward};
        stb_ext = {fsr_pkg::EXT_RESERVED, oc_q[fsr_pkg::OC_SEL_LO], wdata_tog_q,
                   rdata_tog_q, engine.write_gate, mot[1], mot[0]};
        stb_cmp = {pin_f.second_drive_present_low, !drive_sel_out[1], !drive_sel_out[0],
                   wdata_ff_q, rdata_ff_q, write_gate_ff_q,
                   !drive_sel_out[3], !drive_sel_out[2]};
    end

    // Host read port: data and enable one cycle after the strobe
    logic [7:0] rd_d;
    logic rd_oe_d;

    always_comb begin
        rd_d = 8'h00;
        rd_oe_d = 1'b0;
        if (io_rd) begin
            unique case (io_addr)
                fsr_pkg::OFS_STATUS_A: begin
                    rd_d = mode_cmp ? sta_cmp : sta_ext;
                    rd_oe_d = !mode_basic;
                end
                fsr_pkg::OFS_STATUS_B: begin
                    rd_d = mode_cmp ? stb_cmp : stb_ext;
                    rd_oe_d = !mode_basic;
                end
                fsr_pkg::OFS_OUTPUT_CONTROL: begin
                    rd_d = oc_q;
                    rd_oe_d = 1'b1;
                end
                default: begin
                    rd_d = 8'h00;
                    rd_oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            io_rdata <= 8'h00;
            io_rdata_oe <= 1'b0;
        end else begin
            io_rdata <= rd_d;
            io_rdata_oe <= rd_oe_d;
        end
    end

endmodule : fsr_regs

// file: fsr_regs_monitor.sv
// Checker for the floppy status and output control registers
`timescale 1ns/1ps
module fsr_regs_monitor #(
    parameter int CLK_PERIOD_PS = 4000,
    parameter int SOFT_RESET_MIN_NS = 100
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [2:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_rdata_oe,
    input wire fsr_pkg::fsr_cfg_s cfg,
    input wire logic soft_reset_n,
    input wire logic [3:0] drive_sel_out,
    input wire logic [3:0] motor_out,
    input wire logic drive_sel_pin0_low,
    input wire logic drive_sel_pin1_low,
    input wire logic motor_pin0_low,
    input wire logic motor_pin1_low,
    input wire logic dma_req_oe,
    input wire logic fdc_irq_oe,
    input wire logic dma_ack_gated_low,
    input wire logic term_count_gated,
    input wire logic dma_gate_enable
);
    localparam logic [1:0] EXT = fsr_pkg::FSR_MODE_EXTENDED;
    localparam logic [1:0] BAS = fsr_pkg::FSR_MODE_BASIC;
    localparam int SR_MIN = (SOFT_RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    logic [7:0] low_q;
    // Counts sampled cycles of soft reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_q <= 8'h00;
        end else if (soft_reset_n) begin
            low_q <= 8'h00;
        end else if (low_q != 8'hff) begin
            low_q <= low_q + 8'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    basic_hiz_a: assert property (io_rd && io_addr <= 3'h1 && cfg.iface_mode == BAS |=>
        !io_rdata_oe) else $error("status read drove bus in basic mode");
    read_serve_a: assert property (io_rd && (io_addr == 3'h2 ||
        (io_addr == 3'h1 && !cfg.iface_mode[0])) |=> io_rdata_oe) else $error("read not served");
    ext_ones_a: assert property (io_rd && io_addr == 3'h1 && cfg.iface_mode == EXT |=>
        io_rdata[7:6] == 2'h3) else $error("reserved bits not one");
    motor_follow_a: assert property (io_wr && io_addr == 3'h2 |-> ##2
        motor_out == $past(io_wdata[7:4], 2)) else $error("motor outputs wrong");
    sel_onehot_a: assert property (io_wr && io_addr == 3'h2 |-> ##2
        drive_sel_out == (4'h1 << $past(io_wdata[1:0], 2))) else $error("drive select wrong");
    sr_enter_a: assert property (io_wr && io_addr == 3'h2 && !io_wdata[2] |-> ##2
        (!soft_reset_n) [*8]) else $error("soft reset not entered");
    sr_len_a: assert property ($rose(soft_reset_n) |-> low_q >= SR_MIN)
        else $error("soft reset too short");
    dma_oe_a: assert property (dma_req_oe == (cfg.iface_mode == EXT || dma_gate_enable)
        && fdc_irq_oe == dma_req_oe) else $error("dma or irq enable wrong");
    ack_gate_a: assert property (cfg.iface_mode != EXT && $past(cfg.iface_mode) != EXT
        && !$past(dma_gate_enable) |-> dma_ack_gated_low && !term_count_gated)
        else $error("gated inputs passed");
    int_pins_a: assert property (!cfg.external_decode_sel && !cfg.swap_drives && $stable(cfg)
        |-> motor_pin0_low == !motor_out[0] && motor_pin1_low == !motor_out[1]
        && drive_sel_pin0_low == !(drive_sel_out[0] && motor_out[0])
        && drive_sel_pin1_low == !(drive_sel_out[1] && motor_out[1])) else $error("pin decode");
    cover property ($rose(soft_reset_n));
    cover property (io_rd && io_addr == 3'h1 && cfg.iface_mode == EXT);
    cover property (io_rd && io_addr == 3'h0 && cfg.iface_mode == BAS);
endmodule : fsr_regs_monitor

// file: fsr_regs_tb_top.sv
// Testbench for the floppy status and output control registers
`timescale 1ns/1ps
module fsr_regs_tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic io_rd = 1'b0, io_wr = 1'b0, wp = 1'b0, trk = 1'b1, o;
    logic [2:0] io_addr = 3'h0;
    logic [7:0] io_wdata = 8'h00, io_rdata, r, v;
    logic io_rdata_oe, soft_reset_n, ds0_n, ds1_n, m0_n, m1_n, dma_req_oe, dma_gate_enable;
    logic dma_req_pin, fdc_irq_out, fdc_irq_oe, ack_n, tc;
    logic [3:0] drive_sel_out, motor_out;
    fsr_pkg::fsr_cfg_s cfg = '0;
    fsr_pkg::fsr_pins_s pins;
    fsr_pkg::fsr_engine_s engine = '0;
    logic [7:0] vals [4] = '{8'h1c, 8'h2d, 8'h4e, 8'h8f};
    int fail_count = 0, total_checks = 0, n, i;
    fsr_regs dut (.clk, .arst_n, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .io_rdata_oe,
        .cfg, .pins, .engine, .soft_reset_n, .drive_sel_out, .motor_out,
        .drive_sel_pin0_low(ds0_n), .drive_sel_pin1_low(ds1_n), .motor_pin0_low(m0_n),
        .motor_pin1_low(m1_n), .dma_req_pin, .dma_req_oe, .fdc_irq_out, .fdc_irq_oe,
        .dma_ack_gated_low(ack_n), .term_count_gated(tc), .dma_gate_enable);
    fsr_drive_model drv (.clk, .motor_out, .wp, .trk, .pins);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim;
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(negedge clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        r = io_rdata;
        o = io_rdata_oe;
    endtask : rd
    task automatic rc(input logic [2:0] a, input logic [7:0] exp);
        rd(a);
        chk(r, exp);
    endtask : rc
    task automatic idle(input int c);
        repeat (c) @(negedge clk);
    endtask : idle
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        chk(soft_reset_n, 1'b0);
        rc(3'h2, 8'h00);
        chk(o, 1'b1);
        for (i = 0; i < 4; i++) begin
            wr(3'h2, vals[i]);
            idle(1);
            rc(3'h2, vals[i]);
            chk(motor_out, vals[i][7:4]);
            chk(drive_sel_out, 4'h1 << vals[i][1:0]);
            v = {4'h0, ~vals[i][5:4], !(vals[i][1:0] == 2'h1 && vals[i][5]),
                !(vals[i][1:0] == 2'h0 && vals[i][4])};
            chk({m1_n, m0_n, ds1_n, ds0_n}, v);
        end
        wr(3'h2, 8'h2d);
        cfg.external_decode_sel = 1'b1;
        idle(3);
        chk({m1_n, m0_n, ds1_n, ds0_n}, 8'h09);
        cfg.external_decode_sel = 1'b0;
        cfg.swap_drives = 1'b1;
        wr(3'h2, 8'h1c);
        idle(3);
        chk({m1_n, m0_n, ds1_n, ds0_n}, 8'h05);
        cfg.swap_drives = 1'b0;
        wr(3'h2, 8'h25);
        cfg.iface_mode = 2'b10;
        idle(1);
        chk(dma_req_oe, 1'b1);
        chk(dma_gate_enable, 1'b0);
        chk({ack_n, tc, fdc_irq_oe}, 3'h3);
        rd(3'h1);
        chk(r & 8'he7, 8'he2);
        v = r;
        engine.write_gate = 1'b1;
        engine.write_data = 1'b1;
        idle(1);
        engine.write_data = 1'b0;
        idle(2);
        rd(3'h1);
        chk(r & 8'he7, 8'he6);
        chk(r[4], !v[4]);
        engine.write_gate = 1'b0;
        wr(3'h2, 8'h21);
        wr(3'h2, 8'h25);
        n = 0;
        while (soft_reset_n !== 1'b1) begin
            n++;
            if (n > 100) begin
                fail_count++;
                end_sim();
            end
            @(negedge clk);
        end
        chk(n >= 23, 1'b1);
        rc(3'h2, 8'h25);
        rd(3'h1);
        chk(r & 8'he7, 8'he2);
        cfg.iface_mode = 2'b11;
        idle(1);
        chk(dma_req_oe, 1'b0);
        chk({ack_n, tc, fdc_irq_oe}, 3'h4);
        rd(3'h0);
        chk(o, 1'b0);
        rd(3'h1);
        chk(o, 1'b0);
        wr(3'h2, 8'h2d);
        chk(dma_req_oe, 1'b1);
        cfg.iface_mode = 2'b00;
        cfg.force_write_protect = 1'b1;
        wr(3'h2, 8'h0c);
        engine.step_inward = 1'b1;
        engine.head_side_select = 1'b1;
        engine.dma_req = 1'b1;
        engine.fdc_irq = 1'b1;
        engine.step_out = 1'b1;
        idle(1);
        engine.step_out = 1'b0;
        idle(6);
        chk({dma_req_pin, fdc_irq_out, ack_n, tc}, 4'hd);
        rc(3'h0, 8'hf2);
        rd(3'h7);
        engine.step_inward = 1'b0;
        cfg.force_write_protect = 1'b0;
        idle(6);
        rc(3'h0, 8'hd1);
        wr(3'h2, 8'h0e);
        rd(3'h7);
        idle(1);
        rc(3'h1, 8'h62);
        engine.write_gate = 1'b1;
        engine.write_data = 1'b1;
        idle(1);
        engine.write_gate = 1'b0;
        engine.write_data = 1'b0;
        idle(1);
        rc(3'h1, 8'h76);
        wr(3'h2, 8'h1e);
        idle(30);
        rc(3'h1, 8'h7e);
        end_sim();
    end
endmodule : fsr_regs_tb_top
bind fsr_regs fsr_regs_monitor #(.CLK_PERIOD_PS(CLK_PERIOD_PS),
    .SOFT_RESET_MIN_NS(SOFT_RESET_MIN_NS)) mon (.clk, .arst_n, .io_addr, .io_rd, .io_wr,
    .io_wdata, .io_rdata, .io_rdata_oe, .cfg, .soft_reset_n, .drive_sel_out, .motor_out,
    .drive_sel_pin0_low, .drive_sel_pin1_low, .motor_pin0_low, .motor_pin1_low, .dma_req_oe,
    .fdc_irq_oe, .dma_ack_gated_low, .term_count_gated, .dma_gate_enable);
